//--- src/bcl_pkg.sv
/*
  Package for the indirect conditional branch unit: field layouts of the
  branch-options field, condition-register field offsets, shorthand option codes.
  Assumes a 32-bit big-endian-numbered instruction word as delivered by decode.
*/
package bcl_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned XLEN         = 32;
  localparam int unsigned OPT_W        = 5;
  localparam int unsigned SEL_W        = 5;
  localparam int unsigned TGT_LOW_ZERO = 2;

  // ----------------------------------------------------------------
  // Branch-options bit positions, numbered MSB-first as 0..4
  // ----------------------------------------------------------------
  localparam int unsigned OPT_COND_IGN = 0;
  localparam int unsigned OPT_COND_VAL = 1;
  localparam int unsigned OPT_CNT_IGN  = 2;
  localparam int unsigned OPT_CNT_ZERO = 3;

  // ----------------------------------------------------------------
  // Shorthand option codes
  // ----------------------------------------------------------------
  localparam logic [4:0] OPT_DNZ_F  = 5'h00;
  localparam logic [4:0] OPT_DZ_F   = 5'h02;
  localparam logic [4:0] OPT_F      = 5'h04;
  localparam logic [4:0] OPT_DNZ_T  = 5'h08;
  localparam logic [4:0] OPT_DZ_T   = 5'h0A;
  localparam logic [4:0] OPT_T      = 5'h0C;
  localparam logic [4:0] OPT_DNZ    = 5'h10;
  localparam logic [4:0] OPT_DZ     = 5'h12;
  localparam logic [4:0] OPT_ALWAYS = 5'h14;

  // ----------------------------------------------------------------
  // Condition-register field offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] CRF_LT = 2'h0;
  localparam logic [1:0] CRF_GT = 2'h1;
  localparam logic [1:0] CRF_EQ = 2'h2;
  localparam logic [1:0] CRF_SO = 2'h3;

  localparam logic [31:0] INSTR_STEP = 32'h0000_0004;
  localparam logic [31:0] CNT_STEP   = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

  // Which register supplies the target.
  typedef enum logic [1:0] {
    BCL_TGT_COUNT = 2'b01,
    BCL_TGT_LINK  = 2'b10
  } bcl_tgt_t;

  // Options bit n counted from the MSB, as the field is written.
  function automatic logic opt_bit(input logic [4:0] opt, input int unsigned n);
    return opt[4 - n];
  endfunction

  // Condition index from a field number and an offset within it.
  function automatic logic [4:0] crf_index(input logic [2:0] field, input logic [1:0] ofs);
    return {field, ofs};
  endfunction

endpackage

//--- src/bcl_cond_eval.sv
/*
  Combinational branch-condition evaluator: decrement, count test,
  condition-bit test. Assumes operands are stable in the cycle they are used.
*/
`timescale 1ns/1ps
module bcl_cond_eval
  import bcl_pkg::*;
(
  // Operands
  input  wire logic [4:0]  i_opt,
  input  wire logic [4:0]  i_sel,
  input  wire logic [31:0] i_count,
  input  wire logic [31:0] i_cond,
  // Results
  output logic [31:0]      o_count_next,
  output logic             o_count_write,
  output logic             o_taken
);

  logic cnt_ign;
  logic cond_bit;
  logic cnt_ok;
  logic cond_ok;

  assign cnt_ign       = opt_bit(i_opt, OPT_CNT_IGN);
  assign o_count_write = ~cnt_ign;
  assign o_count_next  = cnt_ign ? i_count : i_count - CNT_STEP;
  // Bit 0 of the condition register is its MSB.
  assign cond_bit      = i_cond[5'd31 - i_sel];
  assign cnt_ok        = cnt_ign | ((o_count_next == ZERO_WORD) == opt_bit(i_opt, OPT_CNT_ZERO));
  assign cond_ok       = opt_bit(i_opt, OPT_COND_IGN) | (cond_bit == opt_bit(i_opt, OPT_COND_VAL));
  assign o_taken       = cnt_ok & cond_ok;

endmodule // bcl_cond_eval

//--- src/bcl_branch_unit.sv
/*
  Execute stage for branch-to-count and branch-to-link. One instruction is
  accepted per cycle on i_valid; results appear registered one cycle later.
  Assumes the pipeline presents the architectural count, link and condition
  registers current for the instruction, and writes back the o_*_we results.
*/
// Notes on behaviour
// - Options bit 2 clear decrements count register; set leaves it unchanged.
// - Count test passes if bit 2 set or zero-after-decrement equals bit 3.
// - Condition test passes if bit 0 set or chosen bit equals bit 1.
// - Condition-select field picks the single tested condition-register bit.
// - Count-branch target is next count value (decremented if bit 2 clear) upper 30 bits plus two zeros.
// - Link-branch target is link register upper 30 bits plus two zeros.
// - Not taken gives next address equal current address plus 4.
// - Link flag set writes current address plus 4 to link register always.
// - Count-branch with decrement still executes, targeting decremented count.
// - Options 20, index 0 on count-branch: always taken, no decrement.
// - Options 20, index 0 on link-branch: always taken to link target.
// - Options 12 branches when chosen bit is 1, count untouched.
// - Options 4 branches when chosen bit is 0, count untouched.
// - Options 16 decrements, branches when result is nonzero.
// - Options 18 decrements, branches when result is zero.
// - Options 0 and 8 decrement, branch on nonzero and bit 0 or 1.
// - Options 2 and 10 decrement, branch on zero and bit 0 or 1.
// - Field offsets: less, greater, equal, overflow; index is 4*field+offset.
`timescale 1ns/1ps
module bcl_branch_unit
  import bcl_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  // Instruction issue
  input  wire logic        i_valid,
  input  wire logic        i_to_link,
  input  wire logic [4:0]  i_opt,
  input  wire logic [4:0]  i_sel,
  input  wire logic        i_link_flag,
  input  wire logic [31:0] i_cur_addr,
  // Architectural state
  input  wire logic [31:0] i_count_reg,
  input  wire logic [31:0] i_link_reg,
  input  wire logic [31:0] i_cond_reg,
  // Results
  output logic             o_done,
  output logic             o_taken,
  output logic [31:0]      o_next_addr,
  output logic             o_count_we,
  output logic [31:0]      o_count_reg,
  output logic             o_link_we,
  output logic [31:0]      o_link_reg
);

  // ----------------------------------------------------------------
  // Condition evaluation
  // ----------------------------------------------------------------
  logic [31:0] count_next;
  logic        count_write;
  logic        taken;

  bcl_cond_eval u_eval (
    .i_opt         (i_opt),
    .i_sel         (i_sel),
    .i_count       (i_count_reg),
    .i_cond        (i_cond_reg),
    .o_count_next  (count_next),
    .o_count_write (count_write),
    .o_taken       (taken)
  );

  // ----------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------
  bcl_tgt_t    tgt_src;
  logic [31:0] tgt_base;
  logic [31:0] tgt_addr;
  logic [31:0] fall_addr;

  assign tgt_src   = i_to_link ? BCL_TGT_LINK : BCL_TGT_COUNT;
  // The link value is the input, not the pending write, so a linking
  // return reaches its old target.
  assign tgt_base  = (tgt_src == BCL_TGT_LINK) ? i_link_reg : count_next;
  assign tgt_addr  = {tgt_base[31:TGT_LOW_ZERO], {TGT_LOW_ZERO{1'b0}}};
  assign fall_addr = i_cur_addr + INSTR_STEP;

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  logic        done_d, taken_d, cwe_d, lwe_d;
  logic [31:0] next_d, cnt_d, lnk_d;

  assign done_d  = i_valid;
  assign taken_d = i_valid & taken;
  assign next_d  = taken ? tgt_addr : fall_addr;
  assign cwe_d   = i_valid & count_write;
  assign cnt_d   = count_next;
  assign lwe_d   = i_valid & i_link_flag;
  assign lnk_d   = fall_addr;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_done      <= 1'b0;
      o_taken     <= 1'b0;
      o_next_addr <= ZERO_WORD;
      o_count_we  <= 1'b0;
      o_count_reg <= ZERO_WORD;
      o_link_we   <= 1'b0;
      o_link_reg  <= ZERO_WORD;
    end else begin
      o_done      <= done_d;
      o_taken     <= taken_d;
      o_count_we  <= cwe_d;
      o_link_we   <= lwe_d;
      if (i_valid) begin
        o_next_addr <= next_d;
        o_count_reg <= cnt_d;
        o_link_reg  <= lnk_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  sequence s_issue(logic [4:0] opt);
    i_valid && i_opt == opt && i_sel == 5'h00;
  endsequence

  chk_cnt_hold: assert property (i_valid && opt_bit(i_opt, OPT_CNT_IGN) |=> !o_count_we)
    else $error("count written with decrement disabled");
  chk_cnt_dec: assert property (i_valid && !opt_bit(i_opt, OPT_CNT_IGN)
      |=> o_count_we && o_count_reg == $past(i_count_reg) - CNT_STEP)
    else $error("count not decremented by one");
  chk_fall_thru: assert property (i_valid && !taken |=> !o_taken && o_next_addr == $past(i_cur_addr) + INSTR_STEP)
    else $error("fall-through address wrong");
  chk_link_write: assert property (i_valid |=> o_link_we == $past(i_link_flag)
      && (!o_link_we || o_link_reg == $past(i_cur_addr) + INSTR_STEP))
    else $error("link update wrong");
  chk_always_ctr: assert property (s_issue(OPT_ALWAYS) && !i_to_link
      |=> o_taken && !o_count_we && o_next_addr == {$past(i_count_reg[31:2]), 2'b00})
    else $error("unconditional count branch wrong");
  chk_always_lr: assert property (s_issue(OPT_ALWAYS) && i_to_link
      |=> o_taken && o_next_addr == {$past(i_link_reg[31:2]), 2'b00})
    else $error("unconditional link branch wrong");
  chk_true_bit: assert property (i_valid && i_opt == OPT_T
      |=> o_taken == $past(i_cond_reg[5'd31 - i_sel]) && !o_count_we)
    else $error("branch-if-true wrong");
  chk_false_bit: assert property (i_valid && i_opt == OPT_F
      |=> o_taken == !$past(i_cond_reg[5'd31 - i_sel]) && !o_count_we)
    else $error("branch-if-false wrong");
  chk_dnz: assert property (i_valid && i_opt == OPT_DNZ
      |=> o_taken == ($past(i_count_reg) != CNT_STEP))
    else $error("decrement nonzero branch wrong");
  chk_dz: assert property (i_valid && i_opt == OPT_DZ
      |=> o_taken == ($past(i_count_reg) == CNT_STEP))
    else $error("decrement zero branch wrong");
  chk_dnz_cond: assert property (i_valid && (i_opt == OPT_DNZ_F || i_opt == OPT_DNZ_T)
      |=> o_taken == ($past(i_count_reg) != CNT_STEP
          && $past(i_cond_reg[5'd31 - i_sel]) == $past(i_opt[3])))
    else $error("decrement nonzero with bit wrong");
  chk_dz_cond: assert property (i_valid && (i_opt == OPT_DZ_F || i_opt == OPT_DZ_T)
      |=> o_taken == ($past(i_count_reg) == CNT_STEP
          && $past(i_cond_reg[5'd31 - i_sel]) == $past(i_opt[3])))
    else $error("decrement zero with bit wrong");
  chk_dec_target: assert property (i_valid && !i_to_link && taken
      |=> o_next_addr == {o_count_reg[31:2], 2'b00})
    else $error("count target not from decremented value");
  chk_field_eq: assert property (i_valid && i_opt == OPT_T && i_sel == crf_index(3'h0, CRF_EQ)
      |=> o_taken == $past(i_cond_reg[29]))
    else $error("equal offset wrong");

  // ----------------------------------------------------------------
  // Result timing checks
  // ----------------------------------------------------------------
  // Strobes must fall back on idle cycles. Otherwise the pipeline would
  // write back a stale count or link value twice.
  sequence s_quiet;
    !o_done && !o_taken && !o_count_we && !o_link_we;
  endsequence

  sequence s_held;
    $stable(o_next_addr) && $stable(o_count_reg) && $stable(o_link_reg);
  endsequence

  chk_done_pulse: assert property (i_valid |=> o_done)
    else $error("no result one cycle after issue");
  chk_idle_quiet: assert property (!i_valid |=> s_quiet)
    else $error("strobe raised without an instruction");
  chk_data_held: assert property (!i_valid |=> s_held)
    else $error("result data changed without an instruction");

  // ----------------------------------------------------------------
  // Count register checks
  // ----------------------------------------------------------------
  chk_cnt_same: assert property (i_valid && opt_bit(i_opt, OPT_CNT_IGN)
      |=> o_count_reg == $past(i_count_reg))
    else $error("count value changed with decrement disabled");
  chk_cnt_wrap: assert property (i_valid && !opt_bit(i_opt, OPT_CNT_IGN) && i_count_reg == ZERO_WORD
      |=> o_count_we && o_count_reg == 32'hFFFF_FFFF)
    else $error("decrement of zero did not wrap");

  // ----------------------------------------------------------------
  // Target and write-enable checks
  // ----------------------------------------------------------------
  chk_ctr_target: assert property (i_valid && !i_to_link && taken && opt_bit(i_opt, OPT_CNT_IGN)
      |=> o_taken && o_next_addr == {$past(i_count_reg[31:2]), 2'b00})
    else $error("count target wrong");
  chk_lr_target: assert property (i_valid && i_to_link && taken
      |=> o_taken && o_next_addr == {$past(i_link_reg[31:2]), 2'b00})
    else $error("link target wrong");
  chk_lr_no_cnt: assert property (s_issue(OPT_ALWAYS) && i_to_link |=> !o_count_we)
    else $error("unconditional link branch touched count");
  chk_link_off: assert property (i_valid && !i_link_flag |=> !o_link_we)
    else $error("link written with link flag clear");

  // ----------------------------------------------------------------
  // Field offset checks
  // ----------------------------------------------------------------
  chk_field_lt: assert property (i_valid && i_opt == OPT_T && i_sel == crf_index(3'h1, CRF_LT)
      |=> o_taken == $past(i_cond_reg[27]))
    else $error("less-than offset wrong");
  chk_field_gt: assert property (i_valid && i_opt == OPT_T && i_sel == crf_index(3'h2, CRF_GT)
      |=> o_taken == $past(i_cond_reg[22]))
    else $error("greater-than offset wrong");
  chk_field_so: assert property (i_valid && i_opt == OPT_F && i_sel == crf_index(3'h7, CRF_SO)
      |=> o_taken == !$past(i_cond_reg[0]))
    else $error("overflow offset wrong");

endmodule // bcl_branch_unit

//--- dv/tb_top.sv
/*
  Self-checking testbench for the indirect conditional branch unit.
  Assumes one 25 MHz clock, a synchronous active-high reset, and results that
  appear one cycle after the edge at which i_valid is sampled.
*/
`timescale 1ns/1ps
module tb_top;
  import bcl_pkg::*;

  typedef struct packed {
    logic        taken;
    logic [31:0] nxt;
    logic        cwe;
    logic [31:0] cnt;
    logic        lwe;
    logic [31:0] lnk;
  } bcl_exp_t;

  logic        i_clk_sys, i_srst, i_valid, i_to_link, i_link_flag;
  logic [4:0]  i_opt, i_sel;
  logic [31:0] i_cur_addr, i_count_reg, i_link_reg, i_cond_reg;
  logic        o_done, o_taken, o_count_we, o_link_we;
  logic [31:0] o_next_addr, o_count_reg, o_link_reg;
  int          fail_count, checks_done;
  bcl_exp_t    exp_q[$];
  logic [4:0]  codes [9] = '{OPT_DNZ_F, OPT_DZ_F, OPT_F, OPT_DNZ_T, OPT_DZ_T, OPT_T, OPT_DNZ, OPT_DZ, OPT_ALWAYS};

  bcl_branch_unit i_bcl_branch_unit (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_valid(i_valid), .i_to_link(i_to_link), .i_opt(i_opt),
    .i_sel(i_sel), .i_link_flag(i_link_flag), .i_cur_addr(i_cur_addr), .i_count_reg(i_count_reg),
    .i_link_reg(i_link_reg), .i_cond_reg(i_cond_reg), .o_done(o_done), .o_taken(o_taken),
    .o_next_addr(o_next_addr), .o_count_we(o_count_we), .o_count_reg(o_count_reg),
    .o_link_we(o_link_we), .o_link_reg(o_link_reg));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_front();
    bcl_exp_t e;
    e = exp_q.pop_front();
    check("done", {31'h0, o_done}, 32'h1);
    check("taken", {31'h0, o_taken}, {31'h0, e.taken});
    check("next_addr", o_next_addr, e.nxt);
    check("count_we", {31'h0, o_count_we}, {31'h0, e.cwe});
    if (e.cwe) check("count_val", o_count_reg, e.cnt);
    check("link_we", {31'h0, o_link_we}, {31'h0, e.lwe});
    check("link_val", o_link_reg, e.lnk);
  endtask

  // The expectation is worked out here, before the request goes out.
  task automatic send(input logic tl, input logic [4:0] opt, input logic [4:0] sel, input logic lf,
                      input logic [31:0] addr, input logic [31:0] cnt, input logic [31:0] lnk,
                      input logic [31:0] cr);
    bcl_exp_t    e;
    logic [31:0] c;
    logic        cok, bok;
    c = opt[2] ? cnt : cnt - 32'h1;
    cok = opt[2] | ((c == 32'h0) == opt[1]);
    bok = opt[4] | (cr[31 - sel] == opt[3]);
    e.taken = cok & bok;
    e.nxt = e.taken ? {(tl ? lnk[31:2] : c[31:2]), 2'b00} : addr + 32'h4;
    e.cwe = ~opt[2];
    e.cnt = c;
    e.lwe = lf;
    e.lnk = addr + 32'h4;
    exp_q.push_back(e);
    @(posedge i_clk_sys);
    i_valid <= 1'b1;
    i_to_link <= tl;
    i_opt <= opt;
    i_sel <= sel;
    i_link_flag <= lf;
    i_cur_addr <= addr;
    i_count_reg <= cnt;
    i_link_reg <= lnk;
    i_cond_reg <= cr;
    #1;
    if (exp_q.size() > 1) check_front();
  endtask

  task automatic idle();
    @(posedge i_clk_sys);
    i_valid <= 1'b0;
    #1;
    if (exp_q.size() > 0) check_front();
    else check("idle_taken", {31'h0, o_done, o_taken}, 32'h0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_codes();
    for (int i = 0; i < 9; i++)
      for (int k = 0; k < 8; k++) begin
        send(k[0], codes[i], (codes[i] == OPT_ALWAYS) ? 5'h00 : 5'h06, k[1], 32'h0000_1000 + k * 8,
             k[2] ? 32'h0000_0001 : 32'h8000_0007, 32'h2000_0003, k[1] ? 32'h0200_0000 : 32'hFDFF_FFFF);
        idle();
      end
  endtask

  task automatic t_select();
    for (int s = 0; s < 32; s++) begin
      send(1'b0, OPT_T, s[4:0], 1'b0, 32'h0000_4000, 32'h0000_5001, 32'h0, 32'h8000_0000 >> s);
      send(1'b0, OPT_T, s[4:0], 1'b0, 32'h0000_4004, 32'h0000_5001, 32'h0, ~(32'h8000_0000 >> s));
      idle();
    end
    send(1'b1, OPT_T, 5'h0E, 1'b0, 32'h0000_6000, 32'h0, 32'h0000_7000, 32'h0002_0000);
    send(1'b1, OPT_F, 5'h0D, 1'b0, 32'h0000_6004, 32'h0, 32'h0000_7000, 32'h0002_0000);
    idle();
  endtask

  task automatic t_link();
    send(1'b1, OPT_ALWAYS, 5'h00, 1'b1, 32'h0000_8000, 32'h0, 32'h0000_9003, 32'h0);
    send(1'b1, OPT_ALWAYS, 5'h00, 1'b1, 32'h0000_9000, 32'h0, 32'h0000_8004, 32'h0);
    send(1'b0, OPT_F, 5'h00, 1'b1, 32'h0000_A000, 32'h0, 32'h0, 32'h8000_0000);
    idle();
  endtask

  task automatic t_wrap();
    send(1'b0, OPT_DNZ, 5'h00, 1'b0, 32'h0000_B000, 32'h0, 32'h0, 32'h0);
    send(1'b0, OPT_DZ_T, 5'h1F, 1'b0, 32'h0000_B004, 32'h1, 32'h0, 32'h0000_0001);
    idle();
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  initial begin
    {i_srst, i_valid, i_to_link, i_link_flag, i_opt, i_sel} = '0;
    {i_cur_addr, i_count_reg, i_link_reg, i_cond_reg} = '0;
    i_srst = 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    check("reset_done", {31'h0, o_done}, 32'h0);
    check("reset_next", o_next_addr, 32'h0);
    @(posedge i_clk_sys);
    i_srst <= 1'b0;
    t_codes();
    t_select();
    t_link();
    t_wrap();
    idle();
    wrap_up();
  end

  // A hang ends the run through the same closing report.
  initial begin
    #2000000;
    fail_count++;
    wrap_up();
  end
endmodule // tb_top
